//--- src/sfi_pkg.sv
// shared constants and types of the serial flash interface
`default_nettype none
package sfi_pkg;
   // array geometry
   localparam int ADDR_W       = 8;
   localparam int ARRAY_BYTES  = 256;
   localparam int PAGE_BYTES   = 16;
   localparam int SECTOR_BYTES = 64;
   localparam int BLOCK_BYTES  = 128;
   localparam int PAGE_W       = 4;
   // serial framing
   localparam int ADDR_BYTES   = 3;
   localparam int DUMMY_CLKS   = 8;
   localparam int FIFO_DEPTH   = 4;
   localparam int DATA_W       = 8;
   // command codes
   localparam logic [7:0] OP_READ   = 8'h10;
   localparam logic [7:0] OP_DREAD  = 8'h11;
   localparam logic [7:0] OP_STATUS = 8'h20;
   localparam logic [7:0] OP_PROG   = 8'h30;
   localparam logic [7:0] OP_SERASE = 8'h40;
   localparam logic [7:0] OP_BERASE = 8'h41;
   localparam logic [7:0] OP_CERASE = 8'h42;
   // status byte layout
   localparam int ST_WIP_BIT  = 0;
   localparam int ST_FAIL_BIT = 1;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] IDLE_BYTE   = 8'hFF;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_TIME_NS  = 20000;
   localparam int ERASE_TIME_NS = 100000;
   localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W       = 24;

   typedef enum logic [2:0] {
      S_IDLE, S_CMD, S_ADDR, S_DUMMY, S_DOUT, S_DIN, S_STAT, S_DROP
   } sfi_ser_t;

   typedef enum logic [1:0] {
      E_IDLE, E_WAIT, E_APPLY, E_VERIFY
   } sfi_eng_t;
endpackage
`default_nettype wire

//--- src/sfi_stream_if.sv
// byte stream between the array fetcher, the read fifo and the output shifter
`default_nettype none
interface sfi_stream_if #(parameter int W = 8);
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;
   logic         flush;

   modport fifo (input push_valid, push_data, pop_ready, flush,
                 output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready, flush,
                 input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

//--- src/sfi_fifo.sv
// small flip-flop fifo with flush
`default_nettype none
module sfi_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic rstn,
   sfi_stream_if.fifo q
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0]   cnt_reg;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == LAST_PTR) ? '0 : p + 1'b1;
   endfunction

   wire do_push = q.push_valid & q.push_ready;
   wire do_pop  = q.pop_valid & q.pop_ready;

   assign q.push_ready = (cnt_reg != FULL_CNT);
   assign q.pop_valid  = (cnt_reg != '0);
   assign q.pop_data   = mem_reg[rp_reg];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else if (q.flush) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (do_push) wp_reg <= ptr_inc(wp_reg);
         if (do_pop) rp_reg <= ptr_inc(rp_reg);
         if (do_push && !do_pop) cnt_reg <= cnt_reg + 1'b1;
         else if (do_pop && !do_push) cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // storage needs no reset: the count hides stale words
   always_ff @(posedge mclk) begin
      if (do_push) mem_reg[wp_reg] <= q.push_data;
   end
endmodule
`default_nettype wire

//--- src/sfi_top.sv
// serial flash device: serial front end, read stream, program/erase engine
`default_nettype none
module sfi_top
   import sfi_pkg::*;
#(
   parameter int PROG_CNT  = PROG_CYCLES,
   parameter int ERASE_CNT = ERASE_CYCLES
) (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic pause_n,
   input  wire logic lane0_in,
   output var  logic lane0_out,
   output var  logic lane0_oe,
   input  wire logic lane1_in,
   output var  logic lane1_out,
   output var  logic lane1_oe,
   output var  logic standby,
   output var  logic write_in_progress
);
   // serial front end state
   sfi_ser_t            st_reg;
   logic                sclk_q_reg;
   logic                cs_n_q_reg;
   logic [2:0]          bit_cnt_reg;
   logic [7:0]          in_sr_reg;
   logic [23:0]         addr_reg;
   logic [1:0]          addr_cnt_reg;
   logic [3:0]          dummy_cnt_reg;
   logic [7:0]          op_reg;
   logic                dual_reg;
   logic                armed_reg;
   logic [7:0]          out_sr_reg;
   logic [2:0]          out_cnt_reg;
   logic [7:0]          pbuf_reg [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pmask_reg;
   logic                fetch_en_reg;
   logic [ADDR_W-1:0]   fetch_addr_reg;
   // engine state
   sfi_eng_t            eng_reg;
   logic [TIMER_W-1:0]  timer_reg;
   logic [ADDR_W:0]     idx_reg;
   logic [ADDR_W:0]     len_reg;
   logic [ADDR_W-1:0]   base_reg;
   logic                is_prog_reg;
   logic                wip_reg;
   logic                fail_reg;
   logic [7:0]          mem_reg [ARRAY_BYTES];

   sfi_stream_if #(.W(DATA_W)) rq ();

   sfi_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk (mclk),
      .rstn (rstn),
      .q    (rq)
   );

   function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a, input int size);
      return a & ~ADDR_W'(size - 1);
   endfunction

   function automatic logic is_erase(input logic [7:0] op);
      return (op == OP_SERASE) || (op == OP_BERASE) || (op == OP_CERASE);
   endfunction

   // edge qualification
   wire selected  = ~cs_n;
   wire live      = selected & pause_n;
   wire sclk_rise = live & sclk & ~sclk_q_reg;
   wire sclk_fall = live & ~sclk & sclk_q_reg;
   wire cs_rise   = cs_n & ~cs_n_q_reg;
   wire busy      = wip_reg;

   wire [7:0]        in_byte   = {in_sr_reg[6:0], lane0_in};
   wire              byte_done = sclk_rise & (bit_cnt_reg == 3'd7);
   wire [23:0]       addr_full = {addr_reg[15:0], in_byte};
   wire              addr_last = (addr_cnt_reg == 2'(ADDR_BYTES - 1));
   wire [PAGE_W-1:0] din_off   = addr_reg[PAGE_W-1:0];

   // command decode
   wire is_rd    = (in_byte == OP_READ);
   wire is_drd   = (in_byte == OP_DREAD);
   wire is_stat  = (in_byte == OP_STATUS);
   wire is_wr    = (in_byte == OP_PROG) || (in_byte == OP_SERASE) || (in_byte == OP_BERASE);
   wire is_chip  = (in_byte == OP_CERASE);

   // output shifter
   // widen before shifting so the fail bit is not lost to a one-bit shift
   wire [7:0] status_byte = (8'(wip_reg) << ST_WIP_BIT) | (8'(fail_reg) << ST_FAIL_BIT);
   wire       out_state   = (st_reg == S_DOUT) || (st_reg == S_STAT);
   wire       out_load    = (out_cnt_reg == 3'd0);
   wire [7:0] load_byte   = (st_reg == S_STAT) ? status_byte :
                            (rq.pop_valid ? rq.pop_data : IDLE_BYTE);
   wire [7:0] cur_byte    = out_load ? load_byte : out_sr_reg;

   assign rq.pop_ready  = sclk_fall & (st_reg == S_DOUT) & out_load;
   assign rq.push_valid = fetch_en_reg;
   assign rq.push_data  = mem_reg[fetch_addr_reg];
   assign rq.flush      = cs_n_q_reg;

   // engine addressing
   wire [ADDR_W-1:0] eng_addr = base_reg + idx_reg[ADDR_W-1:0];
   wire [PAGE_W-1:0] eng_off  = eng_addr[PAGE_W-1:0];
   wire              eng_last = (idx_reg == len_reg - 1'b1);
   wire              start    = cs_rise & armed_reg & (eng_reg == E_IDLE) & ~busy;
   wire              prog_bad = pmask_reg[eng_off] & (|(mem_reg[eng_addr] & ~pbuf_reg[eng_off]));
   wire              ers_bad  = (mem_reg[eng_addr] != ERASED_BYTE);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sclk_q_reg <= 1'b0;
         cs_n_q_reg <= 1'b1;
      end else begin
         sclk_q_reg <= sclk;
         cs_n_q_reg <= cs_n;
      end
   end

   // serial front end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_reg        <= S_IDLE;
         bit_cnt_reg   <= '0;
         in_sr_reg     <= '0;
         addr_reg      <= '0;
         addr_cnt_reg  <= '0;
         dummy_cnt_reg <= '0;
         op_reg        <= '0;
         dual_reg      <= 1'b0;
         armed_reg     <= 1'b0;
         pmask_reg     <= '0;
      end else if (!selected) begin
         st_reg       <= S_IDLE;
         bit_cnt_reg  <= '0;
         addr_cnt_reg <= '0;
         dual_reg     <= 1'b0;
         if (cs_rise) armed_reg <= 1'b0;
      end else if (sclk_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
         in_sr_reg   <= in_byte;
         unique case (st_reg)
            S_IDLE: begin
               st_reg      <= S_CMD;
               bit_cnt_reg <= 3'd1;
            end
            S_CMD: if (byte_done) begin
               op_reg    <= in_byte;
               dual_reg  <= is_drd;
               armed_reg <= 1'b0;
               if (is_stat) st_reg <= S_STAT;
               else if ((is_rd || is_drd) && !busy) st_reg <= S_ADDR;
               else if (is_wr && !busy) st_reg <= S_ADDR;
               else if (is_chip && !busy) begin
                  st_reg    <= S_DROP;
                  armed_reg <= 1'b1;
               end else st_reg <= S_DROP;
            end
            S_ADDR: if (byte_done) begin
               addr_reg     <= addr_full;
               addr_cnt_reg <= addr_cnt_reg + 1'b1;
               if (addr_last) begin
                  dummy_cnt_reg <= '0;
                  pmask_reg     <= '0;
                  if (op_reg == OP_READ) st_reg <= S_DOUT;
                  else if (op_reg == OP_DREAD) st_reg <= S_DUMMY;
                  else if (op_reg == OP_PROG) st_reg <= S_DIN;
                  else if (is_erase(op_reg)) begin
                     st_reg    <= S_DROP;
                     armed_reg <= 1'b1;
                  end else st_reg <= S_DROP;
               end
            end
            S_DUMMY: begin
               dummy_cnt_reg <= dummy_cnt_reg + 1'b1;
               if (dummy_cnt_reg == 4'(DUMMY_CLKS - 1)) st_reg <= S_DOUT;
            end
            S_DIN: if (byte_done) begin
               // page program wraps inside the page; a single byte is a byte program
               pmask_reg[din_off] <= 1'b1;
               addr_reg[PAGE_W-1:0] <= din_off + 1'b1;
               armed_reg <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // program data buffer, no reset: the mask qualifies it
   always_ff @(posedge mclk) begin
      if (selected && st_reg == S_DIN && byte_done) pbuf_reg[din_off] <= in_byte;
   end

   // array fetcher: the fifo's ready stalls it, so reads never skip an address
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fetch_en_reg   <= 1'b0;
         fetch_addr_reg <= '0;
      end else if (!selected) begin
         fetch_en_reg <= 1'b0;
      end else if (st_reg == S_ADDR && byte_done && addr_last &&
                   (op_reg == OP_READ || op_reg == OP_DREAD)) begin
         fetch_en_reg   <= 1'b1;
         fetch_addr_reg <= addr_full[ADDR_W-1:0];
      end else if (rq.push_valid && rq.push_ready) begin
         fetch_addr_reg <= fetch_addr_reg + 1'b1;
      end
   end

   // output shifting on the falling serial edge
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_sr_reg  <= '0;
         out_cnt_reg <= '0;
         lane0_out   <= 1'b0;
         lane1_out   <= 1'b0;
      end else if (!selected || !out_state) begin
         out_cnt_reg <= '0;
      end else if (sclk_fall) begin
         lane1_out <= cur_byte[7];
         if (dual_reg) begin
            lane0_out   <= cur_byte[6];
            out_sr_reg  <= {cur_byte[5:0], 2'b00};
            out_cnt_reg <= out_load ? 3'd3 : out_cnt_reg - 1'b1;
         end else begin
            out_sr_reg  <= {cur_byte[6:0], 1'b0};
            out_cnt_reg <= out_load ? 3'd7 : out_cnt_reg - 1'b1;
         end
      end
   end

   // lane enables; a pause releases the lanes without losing the position
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lane0_oe <= 1'b0;
         lane1_oe <= 1'b0;
         standby  <= 1'b1;
      end else begin
         lane1_oe <= live & out_state;
         lane0_oe <= live & dual_reg & (st_reg == S_DOUT);
         standby  <= cs_n & ~wip_reg & ~start & (eng_reg == E_IDLE);
      end
   end

   // self-timed program / erase engine
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         eng_reg     <= E_IDLE;
         timer_reg   <= '0;
         idx_reg     <= '0;
         len_reg     <= '0;
         base_reg    <= '0;
         is_prog_reg <= 1'b0;
         wip_reg     <= 1'b0;
         fail_reg    <= 1'b0;
      end else begin
         unique case (eng_reg)
            E_IDLE: if (start) begin
               eng_reg     <= E_WAIT;
               wip_reg     <= 1'b1;
               fail_reg    <= 1'b0;
               idx_reg     <= '0;
               is_prog_reg <= (op_reg == OP_PROG);
               if (op_reg == OP_PROG) begin
                  timer_reg <= TIMER_W'(PROG_CNT - 1);
                  base_reg  <= align(addr_reg[ADDR_W-1:0], PAGE_BYTES);
                  len_reg   <= (ADDR_W+1)'(PAGE_BYTES);
               end else begin
                  timer_reg <= TIMER_W'(ERASE_CNT - 1);
                  if (op_reg == OP_SERASE) begin
                     base_reg <= align(addr_reg[ADDR_W-1:0], SECTOR_BYTES);
                     len_reg  <= (ADDR_W+1)'(SECTOR_BYTES);
                  end else if (op_reg == OP_BERASE) begin
                     base_reg <= align(addr_reg[ADDR_W-1:0], BLOCK_BYTES);
                     len_reg  <= (ADDR_W+1)'(BLOCK_BYTES);
                  end else begin
                     base_reg <= '0;
                     len_reg  <= (ADDR_W+1)'(ARRAY_BYTES);
                  end
               end
            end
            E_WAIT: begin
               if (timer_reg == '0) eng_reg <= E_APPLY;
               else timer_reg <= timer_reg - 1'b1;
            end
            E_APPLY: begin
               idx_reg <= eng_last ? '0 : idx_reg + 1'b1;
               if (eng_last) eng_reg <= E_VERIFY;
            end
            E_VERIFY: begin
               if (is_prog_reg ? prog_bad : ers_bad) fail_reg <= 1'b1;
               idx_reg <= idx_reg + 1'b1;
               if (eng_last) begin
                  eng_reg <= E_IDLE;
                  wip_reg <= 1'b0;
               end
            end
            default: eng_reg <= E_IDLE;
         endcase
      end
   end

   // the array starts erased; only the engine writes it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < ARRAY_BYTES; i++) mem_reg[i] <= ERASED_BYTE;
      end else if (eng_reg == E_APPLY) begin
         if (!is_prog_reg) mem_reg[eng_addr] <= ERASED_BYTE;
         else if (pmask_reg[eng_off]) mem_reg[eng_addr] <= mem_reg[eng_addr] & pbuf_reg[eng_off];
      end
   end

   assign write_in_progress = wip_reg;
endmodule
`default_nettype wire

//--- sim/sfi_top_asserts.sv
// port-level checker of the serial flash device
`default_nettype none
module sfi_top_asserts
   import sfi_pkg::*;
#(
   parameter int PROG_CNT  = 5,
   parameter int ERASE_CNT = 5
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic pause_n,
   input wire logic lane0_in,
   input wire logic lane0_out,
   input wire logic lane0_oe,
   input wire logic lane1_in,
   input wire logic lane1_out,
   input wire logic lane1_oe,
   input wire logic standby,
   input wire logic write_in_progress
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_LEN = (PROG_CNT < ERASE_CNT ? PROG_CNT : ERASE_CNT) + 30;
   logic [TIMER_W-1:0] wip_len_reg;
   // length of the current busy spell, cleared when idle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) wip_len_reg <= '0;
      else if (write_in_progress) wip_len_reg <= wip_len_reg + 24'h000001;
      else wip_len_reg <= '0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_standby_sel; !cs_n [*2] |-> !standby; endproperty
   a_standby_sel: assert property (p_standby_sel) else $error("standby while selected");
   property p_standby_idle; (cs_n && !write_in_progress) [*3] |-> standby; endproperty
   a_standby_idle: assert property (p_standby_idle) else $error("no standby when idle");
   property p_oe_desel; cs_n [*2] |-> !lane1_oe && !lane0_oe; endproperty
   a_oe_desel: assert property (p_oe_desel) else $error("lane driven while deselected");
   property p_oe_pause; !pause_n [*2] |-> !lane1_oe && !lane0_oe; endproperty
   a_oe_pause: assert property (p_oe_pause) else $error("lane driven while paused");
   property p_dual_pair; lane0_oe |-> lane1_oe; endproperty
   a_dual_pair: assert property (p_dual_pair) else $error("lane0 driven alone");
   // bits may only move on a falling serial clock, never during a high phase
   property p_out_edge;
      lane1_oe && $past(lane1_oe) && $changed(lane1_out) |-> !$past(sclk) || !$past(sclk, 2);
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("output moved without clock fall");
   property p_wip_start; $rose(write_in_progress) |-> $past(cs_n); endproperty
   a_wip_start: assert property (p_wip_start) else $error("busy began while selected");
   property p_wip_min; $fell(write_in_progress) |-> wip_len_reg >= MIN_LEN; endproperty
   a_wip_min: assert property (p_wip_min) else $error("busy spell too short");
   property p_wip_max; write_in_progress |-> wip_len_reg < ERASE_CNT + 600; endproperty
   a_wip_max: assert property (p_wip_max) else $error("busy never ends");
endmodule
bind sfi_top sfi_top_asserts #(.PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT)) u_chk (
   .mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .pause_n(pause_n),
   .lane0_in(lane0_in), .lane0_out(lane0_out), .lane0_oe(lane0_oe), .lane1_in(lane1_in),
   .lane1_out(lane1_out), .lane1_oe(lane1_oe), .standby(standby),
   .write_in_progress(write_in_progress));
`default_nettype wire

//--- sim/sfi_host_model.sv
// serial bus host driving the flash device, mode 0, msb first
`default_nettype none
module sfi_host_model
   import sfi_pkg::*;
(
   input  wire logic mclk,
   input  wire logic lane1,
   input  wire logic lane0,
   output var  logic cs_n,
   output var  logic sclk,
   output var  logic pause_n,
   output var  logic mosi,
   output var  logic mosi_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      pause_n = 1'b1;
      mosi = 1'b0;
      mosi_oe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // four mclk per phase keeps above the three the device needs
   task automatic xbit(input logic d, input logic dual, output logic q1, output logic q0);
      @(posedge mclk);
      sclk <= 1'b0;
      mosi <= d;
      mosi_oe <= !dual;
      tick(3);
      q1 = lane1;
      q0 = lane0;
      @(posedge mclk);
      sclk <= 1'b1;
      tick(3);
   endtask
   task automatic xbyte(input logic [7:0] d, input logic dual, output logic [7:0] q);
      logic b1;
      logic b0;
      for (int i = 7; i >= 0; i--) begin
         if (dual && (i % 2 == 0)) continue;
         xbit(d[i], dual, b1, b0);
         q[i] = b1;
         if (dual) q[i-1] = b0;
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic adr_en, input logic [7:0] adr);
      logic [7:0] q;
      @(posedge mclk);
      cs_n <= 1'b0;
      xbyte(op, 1'b0, q);
      if (adr_en) begin
         xbyte(8'h00, 1'b0, q);
         xbyte(8'h00, 1'b0, q);
         xbyte(adr, 1'b0, q);
      end
   endtask
   // clock parks low between frames
   task automatic stop();
      @(posedge mclk);
      sclk <= 1'b0;
      cs_n <= 1'b1;
      mosi_oe <= 1'b0;
      tick(4);
   endtask
   task automatic pause(input logic v);
      @(posedge mclk);
      pause_n <= v;
   endtask
   // status is re-read until the busy bit clears; bounded so a stuck device shows up
   task automatic poll(output logic [7:0] st);
      cmd(OP_STATUS, 1'b0, 8'h00);
      for (int n = 0; n < 40; n++) begin
         xbyte(8'h00, 1'b0, st);
         if (st[ST_WIP_BIT] == 1'b0) break;
      end
      stop();
   endtask
endmodule
`default_nettype wire

//--- sim/serial_flash_interface_bench.sv
// self-checking bench of the serial flash device
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module serial_flash_interface_bench
   import sfi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PCNT = 600;
   localparam int ECNT = 600;
   logic mclk            = 1'b0;
   logic rstn            = 1'b0;
   logic tgl             = 1'b0;
   int   error_cnt       = 0;
   int   samples_checked = 0;
   wire logic cs_n, sclk, pause_n, mosi, mosi_oe;
   logic      lane0_out, lane0_oe, lane1_out, lane1_oe, standby, write_in_progress_flag;
   // released lines wander so a stale value can never read as data
   wire logic lane0_w = lane0_oe ? lane0_out : (mosi_oe ? mosi : tgl);
   wire logic lane1_w = lane1_oe ? lane1_out : tgl;
   always #5 mclk = ~mclk;
   always @(posedge mclk) tgl <= ~tgl;
   sfi_top #(.PROG_CNT(PCNT), .ERASE_CNT(ECNT)) u_dut (
      .mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .pause_n(pause_n),
      .lane0_in(lane0_w), .lane0_out(lane0_out), .lane0_oe(lane0_oe),
      .lane1_in(lane1_w), .lane1_out(lane1_out), .lane1_oe(lane1_oe),
      .standby(standby), .write_in_progress(write_in_progress_flag));
   sfi_host_model u_host (
      .mclk(mclk), .lane1(lane1_w), .lane0(lane0_w), .cs_n(cs_n), .sclk(sclk),
      .pause_n(pause_n), .mosi(mosi), .mosi_oe(mosi_oe));
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk_rd(input logic [7:0] adr, input logic dual, input logic [7:0] e0, e1);
      logic [7:0] q0;
      logic [7:0] q1;
      u_host.cmd(dual ? OP_DREAD : OP_READ, 1'b1, adr);
      if (dual) u_host.xbyte(8'h00, 1'b0, q0);
      u_host.xbyte(8'h00, dual, q0);
      u_host.xbyte(8'h00, dual, q1);
      u_host.stop();
      `CHK(q0, e0)
      `CHK(q1, e1)
   endtask
   task automatic prog1(input logic [7:0] adr);
      logic [7:0] q;
      u_host.cmd(OP_PROG, 1'b1, adr);
      u_host.xbyte(8'h00, 1'b0, q);
      u_host.stop();
   endtask
   task automatic t_reset();
      `CHK(standby, 1'b1)
      `CHK(write_in_progress_flag, 1'b0)
   endtask
   // three bytes from 0x0E wrap inside the page onto 0x00
   task automatic t_prog();
      logic [7:0] q;
      logic [7:0] st;
      u_host.cmd(OP_PROG, 1'b1, 8'h0E);
      u_host.xbyte(8'hA5, 1'b0, q);
      u_host.xbyte(8'h3C, 1'b0, q);
      u_host.xbyte(8'h5A, 1'b0, q);
      u_host.stop();
      `CHK(write_in_progress_flag, 1'b1)
      `CHK(standby, 1'b0)
      u_host.poll(st);
      `CHK(st, 8'h00)
      chk_rd(8'h0E, 1'b0, 8'hA5, 8'h3C);
      chk_rd(8'h0F, 1'b0, 8'h3C, 8'hFF);
      chk_rd(8'hFF, 1'b0, 8'hFF, 8'h5A);
      chk_rd(8'h0E, 1'b1, 8'hA5, 8'h3C);
   endtask
   // clocks while deselected or paused must not move the transfer
   task automatic t_pause();
      logic [7:0] q;
      logic       b1;
      logic       b0;
      u_host.xbyte(8'hFF, 1'b0, q);
      u_host.cmd(OP_READ, 1'b1, 8'h0E);
      for (int i = 7; i >= 4; i--) begin
         u_host.xbit(1'b0, 1'b0, b1, b0);
         q[i] = b1;
      end
      u_host.pause(1'b0);
      u_host.xbit(1'b1, 1'b0, b1, b0);
      `CHK(lane1_oe, 1'b0)
      u_host.pause(1'b1);
      for (int i = 3; i >= 0; i--) begin
         u_host.xbit(1'b0, 1'b0, b1, b0);
         q[i] = b1;
      end
      u_host.stop();
      `CHK(q, 8'hA5)
   endtask
   // second program lands while busy and must be dropped
   task automatic t_busy();
      logic [7:0] st;
      prog1(8'h40);
      prog1(8'h41);
      u_host.poll(st);
      `CHK(st, 8'h00)
      chk_rd(8'h40, 1'b0, 8'h00, 8'hFF);
   endtask
   // sector and block erase checked at their upper boundary; chip erase checked at 0x80
   task automatic t_erase();
      logic [7:0] st;
      logic [7:0] ops[3]  = '{OP_SERASE, OP_BERASE, OP_CERASE};
      logic [7:0] adrs[3] = '{8'h3F, 8'h7F, 8'h80};
      logic [7:0] nxt[3]  = '{8'h00, 8'h00, 8'hFF};
      prog1(8'h80);
      u_host.poll(st);
      for (int k = 0; k < 3; k++) begin
         u_host.cmd(ops[k], ops[k] != OP_CERASE, 8'h00);
         u_host.stop();
         u_host.poll(st);
         `CHK(st, 8'h00)
         chk_rd(adrs[k], 1'b0, 8'hFF, nxt[k]);
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      u_host.tick(2);
      t_reset();
      t_prog();
      t_pause();
      t_busy();
      t_erase();
      print_verdict();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire
